// File: core/pmv_pkg.sv
// package of constants for the program memory vector map block
package pmv_pkg;
   localparam int ROM_BYTES = 32768;
   localparam int ADDR_W = 15;
   localparam int PC_W = 14;
   localparam logic [ADDR_W-1:0] VEC_BASE = 15'h0000;
   localparam logic [ADDR_W-1:0] VEC_LAST = 15'h000F;
   localparam logic [ADDR_W-1:0] REF_BASE = 15'h0020;
   localparam logic [ADDR_W-1:0] REF_LAST = 15'h007F;
   localparam int NUM_SRC = 8;
   localparam int EMB_BIT = 7;
   localparam int ERB_BIT = 6;
   localparam logic [2:0] SLOT_RESET = 3'h0;
   localparam logic [2:0] SLOT_BTIMER = 3'h1;
   localparam logic [2:0] SLOT_EXT0 = 3'h2;
   localparam logic [2:0] SLOT_EXT1 = 3'h3;
   localparam logic [2:0] SLOT_SERIAL = 3'h4;
   localparam logic [2:0] SLOT_TIMER0 = 3'h5;
   localparam logic [2:0] SLOT_TIMER1 = 3'h6;
   localparam logic [2:0] SLOT_KEY = 3'h7;
   localparam logic [ADDR_W-1:0] PC_RESET = 15'h0000;
   typedef enum logic [1:0] {
      PMV_AREA_VECTOR,
      PMV_AREA_GENERAL,
      PMV_AREA_LOOKUP
   } pmv_area_e;
endpackage : pmv_pkg

// File: core/pmv_rom_if.sv
// interface carrying the byte read port of the program memory
`timescale 1ns/1ns
interface pmv_rom_if;
   logic [pmv_pkg::ADDR_W-1:0] addr;
   logic [7:0] data;
   modport user (output addr, input data);
   modport rom (input addr, output data);
endinterface : pmv_rom_if

// File: core/pmv_rom.sv
// synchronous read-only program memory array
`timescale 1ns/1ns
module pmv_rom #(
   parameter int DEPTH = pmv_pkg::ROM_BYTES
) (
   // clock
   input wire logic mclk,
   // read port
   pmv_rom_if.rom rd,
   // load port for the image
   input wire logic load_en,
   input wire logic [pmv_pkg::ADDR_W-1:0] load_addr,
   input wire logic [7:0] load_data
);
   logic [7:0] mem [DEPTH];
   logic [7:0] data_reg;

   always_ff @(posedge mclk) begin
      if (load_en) begin
         mem[load_addr] <= load_data;
      end
      data_reg <= mem[rd.addr];
   end

   assign rd.data = data_reg;
endmodule : pmv_rom

// File: core/pmv_vector_map.sv
// program counter sequencer with vector fetch and look-up table reference
`timescale 1ns/1ns
module pmv_vector_map (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // program image load, accepted in or out of reset
   input wire logic load_en,
   input wire logic [pmv_pkg::ADDR_W-1:0] load_addr,
   input wire logic [7:0] load_data,
   // interrupt requests, one-cycle pulses accepted when ready
   input wire logic basic_timer_irq,
   input wire logic ext_irq_four,
   input wire logic ext_irq_zero,
   input wire logic ext_irq_one,
   input wire logic serial_port_irq,
   input wire logic timer_zero_irq,
   input wire logic timer_one_irq,
   input wire logic key_input_irq,
   // sequencer requests from the core
   input wire logic fetch_req,
   input wire logic ref_req,
   input wire logic [5:0] ref_index,
   input wire logic [2:0] ref_len,
   // core side results
   output logic [pmv_pkg::ADDR_W-1:0] pc,
   output logic [7:0] code_byte,
   output logic code_valid,
   output logic [pmv_pkg::ADDR_W-1:0] code_addr,
   output logic from_lookup,
   output logic memory_bank_enable_flag,
   output logic register_bank_enable_flag,
   output logic vector_taken,
   output logic [1:0] area,
   output logic busy
);
   typedef enum logic [2:0] {
      PMV_ST_IDLE,
      PMV_ST_VEC_LO,
      PMV_ST_VEC_HI,
      PMV_ST_VEC_DONE,
      PMV_ST_FETCH,
      PMV_ST_REF
   } pmv_state_e;

   pmv_rom_if rom_bus ();

   pmv_rom u_rom (
      .mclk(mclk),
      .rd(rom_bus),
      .load_en(load_en),
      .load_addr(load_addr),
      .load_data(load_data)
   );

   pmv_state_e state_reg, state_next;
   logic [pmv_pkg::ADDR_W-1:0] pc_reg, pc_next;
   logic [pmv_pkg::ADDR_W-1:0] rd_addr_reg, rd_addr_next;
   logic [7:0] hi_reg, hi_next;
   logic emb_reg, emb_next;
   logic erb_reg, erb_next;
   logic taken_reg, taken_next;
   logic [7:0] byte_reg, byte_next;
   logic valid_reg, valid_next;
   logic [pmv_pkg::ADDR_W-1:0] caddr_reg, caddr_next;
   logic lut_reg, lut_next;
   logic [1:0] area_reg, area_next;
   logic [2:0] left_reg, left_next;
   logic rst_vec_reg, rst_vec_next;
   logic busy_reg, busy_next;
   logic [2:0] slot;
   logic irq_any;
   logic [pmv_pkg::ADDR_W-1:0] rd_mux;

   // fixed slot priority in vector order
   always_comb begin
      irq_any = 1'b1;
      slot = pmv_pkg::SLOT_RESET;
      if (basic_timer_irq || ext_irq_four) begin
         slot = pmv_pkg::SLOT_BTIMER;
      end else if (ext_irq_zero) begin
         slot = pmv_pkg::SLOT_EXT0;
      end else if (ext_irq_one) begin
         slot = pmv_pkg::SLOT_EXT1;
      end else if (serial_port_irq) begin
         slot = pmv_pkg::SLOT_SERIAL;
      end else if (timer_zero_irq) begin
         slot = pmv_pkg::SLOT_TIMER0;
      end else if (timer_one_irq) begin
         slot = pmv_pkg::SLOT_TIMER1;
      end else if (key_input_irq) begin
         slot = pmv_pkg::SLOT_KEY;
      end else begin
         irq_any = 1'b0;
      end
   end

   // area classification of the address just read
   function automatic logic [1:0] area_of(
      input logic [pmv_pkg::ADDR_W-1:0] a
   );
      if (a <= pmv_pkg::VEC_LAST) begin
         area_of = 2'(pmv_pkg::PMV_AREA_VECTOR);
      end else if (a >= pmv_pkg::REF_BASE && a <= pmv_pkg::REF_LAST) begin
         area_of = 2'(pmv_pkg::PMV_AREA_LOOKUP);
      end else begin
         area_of = 2'(pmv_pkg::PMV_AREA_GENERAL);
      end
   endfunction : area_of

   always_comb begin
      state_next = state_reg;
      pc_next = pc_reg;
      rd_addr_next = rd_addr_reg;
      hi_next = hi_reg;
      emb_next = emb_reg;
      erb_next = erb_reg;
      taken_next = 1'b0;
      byte_next = byte_reg;
      valid_next = 1'b0;
      caddr_next = caddr_reg;
      lut_next = lut_reg;
      area_next = area_reg;
      left_next = left_reg;
      rst_vec_next = 1'b0;
      rd_mux = rd_addr_reg;
      case (state_reg)
         PMV_ST_IDLE: begin
            if (rst_vec_reg || irq_any) begin
               // even byte of the slot first, reset ahead of any request
               rd_addr_next = pmv_pkg::VEC_BASE + {11'h000,
                  (rst_vec_reg ? pmv_pkg::SLOT_RESET : slot),
                  1'b0};
               state_next = PMV_ST_VEC_LO;
            end else if (ref_req) begin
               // table entries are word aligned
               rd_addr_next = pmv_pkg::REF_BASE
                  + {8'h00, ref_index, 1'b0};
               left_next = (ref_len == 3'h0) ? 3'h1 : ref_len;
               state_next = PMV_ST_REF;
            end else if (fetch_req) begin
               rd_addr_next = pc_reg;
               pc_next = pc_reg + 15'h0001;
               state_next = PMV_ST_FETCH;
            end
            rd_mux = rd_addr_next;
         end
         PMV_ST_VEC_LO: begin
            // even byte is on the read port, odd address issued next
            hi_next = rom_bus.data;
            rd_addr_next = rd_addr_reg + 15'h0001;
            rd_mux = rd_addr_next;
            state_next = PMV_ST_VEC_HI;
         end
         PMV_ST_VEC_HI: begin
            state_next = PMV_ST_VEC_DONE;
         end
         PMV_ST_VEC_DONE: begin
            emb_next = hi_reg[pmv_pkg::EMB_BIT];
            erb_next = hi_reg[pmv_pkg::ERB_BIT];
            pc_next = {1'b0, hi_reg[5:0], rom_bus.data};
            taken_next = 1'b1;
            state_next = PMV_ST_IDLE;
         end
         PMV_ST_FETCH: begin
            byte_next = rom_bus.data;
            caddr_next = rd_addr_reg;
            lut_next = 1'b0;
            area_next = area_of(rd_addr_reg);
            valid_next = 1'b1;
            state_next = PMV_ST_IDLE;
         end
         PMV_ST_REF: begin
            // one byte per cycle until the entry is exhausted
            byte_next = rom_bus.data;
            caddr_next = rd_addr_reg;
            lut_next = 1'b1;
            area_next = area_of(rd_addr_reg);
            valid_next = 1'b1;
            left_next = left_reg - 3'h1;
            if (left_reg == 3'h1) begin
               state_next = PMV_ST_IDLE;
            end else begin
               rd_addr_next = rd_addr_reg + 15'h0001;
               rd_mux = rd_addr_next;
            end
         end
         default: begin
            state_next = PMV_ST_IDLE;
         end
      endcase
      busy_next = (state_next != PMV_ST_IDLE) || rst_vec_next;
   end

   assign rom_bus.addr = rd_mux;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_reg <= PMV_ST_IDLE;
         pc_reg <= pmv_pkg::PC_RESET;
         rd_addr_reg <= pmv_pkg::VEC_BASE;
         hi_reg <= 8'h00;
         emb_reg <= 1'b0;
         erb_reg <= 1'b0;
         taken_reg <= 1'b0;
         byte_reg <= 8'h00;
         valid_reg <= 1'b0;
         caddr_reg <= pmv_pkg::VEC_BASE;
         lut_reg <= 1'b0;
         area_reg <= 2'h0;
         left_reg <= 3'h0;
         rst_vec_reg <= 1'b1;
         busy_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         pc_reg <= pc_next;
         rd_addr_reg <= rd_addr_next;
         hi_reg <= hi_next;
         emb_reg <= emb_next;
         erb_reg <= erb_next;
         taken_reg <= taken_next;
         byte_reg <= byte_next;
         valid_reg <= valid_next;
         caddr_reg <= caddr_next;
         lut_reg <= lut_next;
         area_reg <= area_next;
         left_reg <= left_next;
         rst_vec_reg <= rst_vec_next;
         busy_reg <= busy_next;
      end
   end

   // outputs come straight from flip-flops
   assign pc = pc_reg;
   assign code_byte = byte_reg;
   assign code_valid = valid_reg;
   assign code_addr = caddr_reg;
   assign from_lookup = lut_reg;
   assign memory_bank_enable_flag = emb_reg;
   assign register_bank_enable_flag = erb_reg;
   assign vector_taken = taken_reg;
   assign area = area_reg;
   assign busy = busy_reg;
endmodule : pmv_vector_map

// File: verification/pmv_vector_map_properties.sv
// checker of the vector map sequencer ports
`timescale 1ns/1ns
module pmv_vm_props (
   // clock and reset
   input wire logic mclk, sys_rst,
   // requests
   input wire logic basic_timer_irq, ext_irq_four, ext_irq_zero,
   input wire logic ext_irq_one, serial_port_irq, timer_zero_irq,
   input wire logic timer_one_irq, key_input_irq, fetch_req, ref_req,
   input wire logic [5:0] ref_index,
   // results
   input wire logic [pmv_pkg::ADDR_W-1:0] pc, code_addr,
   input wire logic code_valid, from_lookup, vector_taken, busy,
   input wire logic memory_bank_enable_flag, register_bank_enable_flag,
   input wire logic [1:0] area
);
   logic irq;
   logic take;
   assign irq = basic_timer_irq | ext_irq_four | ext_irq_zero | ext_irq_one
      | serial_port_irq | timer_zero_irq | timer_one_irq | key_input_irq;
   assign take = !busy && !irq;
   function automatic logic [1:0] area_of(input logic [14:0] a);
      if (a <= pmv_pkg::VEC_LAST) return 2'h0;
      if (a >= pmv_pkg::REF_BASE && a <= pmv_pkg::REF_LAST) return 2'h2;
      return 2'h1;
   endfunction : area_of
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   AST_FETCH_ANS: assert property (take && !ref_req && fetch_req |->
      ##2 code_valid && code_addr == $past(pc, 2) && !from_lookup)
      else $error("fetch answer wrong");
   AST_FETCH_INC: assert property (take && !ref_req && fetch_req |->
      ##1 pc == $past(pc) + 15'h0001) else $error("pc not stepped");
   AST_VEC_TAKE: assert property (!busy && irq |->
      ##4 vector_taken && pc[14] == 1'b0) else $error("vector late");
   AST_RST_VEC: assert property ($fell(sys_rst) |->
      ##[3:4] vector_taken) else $error("reset vector missing");
   AST_FLAG_HOLD: assert property (!vector_taken |->
      $stable({memory_bank_enable_flag, register_bank_enable_flag}))
      else $error("flags moved");
   AST_AREA: assert property (code_valid |->
      area == area_of(code_addr)) else $error("area wrong");
   AST_REF_ANS: assert property (take && ref_req |-> ##2
      code_valid && from_lookup && code_addr ==
      pmv_pkg::REF_BASE + {$past(ref_index, 2), 1'b0})
      else $error("reference answer wrong");
   AST_REF_AREA: assert property (code_valid && from_lookup |->
      code_addr inside {[15'h0020:15'h007F]}) else $error("table range");
endmodule : pmv_vm_props
bind pmv_vector_map pmv_vm_props u_props (.*);

// File: verification/pmv_core_model.sv
// model of the core that issues fetch, reference and interrupt requests
`timescale 1ns/1ns
module pmv_core_model (
   // clock and status
   input wire logic mclk,
   input wire logic busy,
   // requests
   output logic [7:0] irq,
   output logic fetch_req,
   output logic ref_req,
   output logic [5:0] ref_index,
   output logic [2:0] ref_len
);
   initial {irq, fetch_req, ref_req, ref_index, ref_len} = 19'h00001;
   // one request, once idle
   task automatic issue(input logic [7:0] i, input logic f, r,
      input logic [5:0] x, input logic [2:0] n);
      while (busy !== 1'b0) @(posedge mclk) #1;
      {irq, fetch_req, ref_req, ref_index, ref_len} = {i, f, r, x, n};
      @(posedge mclk) #1;
      {irq, fetch_req, ref_req, ref_index, ref_len} = {10'h000, ~x, ~n};
   endtask : issue
endmodule : pmv_core_model

// File: verification/test_pmv_vector_map.sv
// self-checking bench of the vector map sequencer
`timescale 1ns/1ns
module test_pmv_vector_map;
   logic mclk, sys_rst, load_en, fetch_req, ref_req, code_valid, busy;
   logic from_lookup, vector_taken;
   logic memory_bank_enable_flag, register_bank_enable_flag;
   logic [pmv_pkg::ADDR_W-1:0] load_addr, pc, code_addr, xpc;
   logic [7:0] load_data, code_byte, irq;
   logic [7:0] img [256];
   logic [5:0] ref_index;
   logic [2:0] ref_len;
   logic [1:0] area;
   logic [23:0] cq [$];
   logic [16:0] vq [$];
   int fails, total_checks;
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   pmv_vector_map dut (.*, .basic_timer_irq(irq[0]),
      .ext_irq_four(irq[1]), .ext_irq_zero(irq[2]), .ext_irq_one(irq[3]),
      .serial_port_irq(irq[4]), .timer_zero_irq(irq[5]),
      .timer_one_irq(irq[6]), .key_input_irq(irq[7]));
   pmv_core_model core (.*);
   task automatic check(input string nm, input logic [23:0] e, s);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   task automatic complete_run;
      if (fails == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : complete_run
   always @(negedge mclk) begin
      if (code_valid === 1'b1) check("code", cq.pop_front(),
         {code_addr, code_byte, from_lookup});
      if (vector_taken === 1'b1) check("vector", vq.pop_front(),
         {pc, memory_bank_enable_flag, register_bank_enable_flag});
   end
   task automatic fetch(input int k);
      for (int j = 0; j < k; j++) begin
         cq.push_back({xpc, img[xpc[7:0]], 1'b0});
         xpc = xpc + 15'h0001;
         core.issue(8'h00, 1'b1, 1'b0, 6'($urandom), 3'h0);
      end
   endtask : fetch
   task automatic refer(input logic [5:0] x, input logic [2:0] n);
      for (int j = 0; j < n + (n == 0); j++)
         cq.push_back({15'(32 + 2 * x + j), img[32 + 2 * x + j], 1'b1});
      core.issue(8'h00, 1'b0, 1'b1, x, n);
   endtask : refer
   task automatic irq_go(input logic [7:0] m, input int s);
      xpc = {1'b0, img[2 * s][5:0], img[2 * s + 1]};
      vq.push_back({xpc, img[2 * s][7:6]});
      core.issue(m, 1'b0, 1'b0, 6'h00, 3'h0);
      fetch(2);
   endtask : irq_go
   initial begin
      void'($urandom(51145));
      {sys_rst, load_en, load_addr, load_data} = {1'b1, 24'h000000};
      for (int a = 0; a < 256; a++) img[a] = 8'($urandom);
      for (int k = 1; k < 8; k++) begin
         img[2 * k] = {img[2 * k][7:6], 6'h00};
         img[2 * k + 1][7] = 1'b0;
      end
      img[0] = 8'h80;
      img[1] = 8'h08;
      repeat (3) @(posedge mclk);
      #1;
      for (int a = 0; a < 256; a++) begin
         {load_en, load_addr, load_data} = {1'b1, 15'(a), img[a]};
         @(posedge mclk) #1;
      end
      {load_en, sys_rst} = 2'h0;
      vq.push_back({15'h0008, 2'h2});
      xpc = 15'h0008;
      fetch(40);
      for (int k = 0; k < 6; k++)
         refer(k == 0 ? 6'h2F : 6'($urandom_range(47)), 3'(k % 4));
      for (int i = 0; i < 8; i++)
         irq_go(8'h01 << i, i == 0 ? 1 : i);
      irq_go(8'h84, 2);
      repeat (10) @(posedge mclk);
      check("left", 24'h000000, 24'(cq.size() + vq.size()));
      complete_run();
   end
   initial begin
      #20000;
      fails++;
      complete_run();
   end
endmodule : test_pmv_vector_map
